// ---- rtl/regbank_pkg.sv ----
// package: register bank and status word constants, types and helpers
package regbank_pkg;

   // ------------------------------------------------------------
   // status word layout
   // ------------------------------------------------------------
   localparam int unsigned FLAG_N_POS = 31;
   localparam int unsigned FLAG_Z_POS = 30;
   localparam int unsigned FLAG_C_POS = 29;
   localparam int unsigned FLAG_V_POS = 28;
   localparam int unsigned FLAG_Q_POS = 27;
   localparam int unsigned MASK_I_POS = 7;
   localparam int unsigned MASK_F_POS = 6;
   localparam int unsigned STATE_T_POS = 5;
   localparam int unsigned MODE_LSB = 0;
   localparam int unsigned MODE_W = 5;
   localparam int unsigned CTRL_W = 8;

   // write field mask bits (flags group and control group)
   localparam logic [3:0] FMASK_FLAGS = 4'h8;
   localparam logic [3:0] FMASK_CTRL = 4'h1;
   localparam logic [31:0] FLAGS_BYTE = 32'hff000000;
   localparam logic [31:0] CTRL_BYTE = 32'h000000ff;
   localparam logic [31:0] MID_BYTES = 32'h00ffff00;

   // ------------------------------------------------------------
   // mode codes
   // ------------------------------------------------------------
   localparam logic [4:0] MODE_USR = 5'h10;
   localparam logic [4:0] MODE_FIQ = 5'h11;
   localparam logic [4:0] MODE_IRQ = 5'h12;
   localparam logic [4:0] MODE_SVC = 5'h13;
   localparam logic [4:0] MODE_ABT = 5'h17;
   localparam logic [4:0] MODE_UND = 5'h1b;
   localparam logic [4:0] MODE_SYS = 5'h1f;

   // reset value of the control group: both masks set, state clear, supervisor
   localparam logic [31:0] STATUS_RESET = 32'h000000d3;
   localparam logic [31:0] ZERO_WORD = 32'h00000000;

   // physical register file: 16 shared + 7 fast-mode r8-r14 + 4x2 banked r13/r14
   // banked pairs start after the fast-mode copies so no two modes share a slot
   localparam int unsigned PHYS_REGS = 31;
   localparam int unsigned PHYS_W = 5;
   localparam int unsigned NUM_SAVED = 5;
   localparam logic [4:0] PHYS_FIQ8 = 5'h10;
   localparam logic [4:0] PHYS_BANK13 = 5'h17;

   typedef enum logic [2:0] {
      BANK_USR,
      BANK_FIQ,
      BANK_IRQ,
      BANK_SVC,
      BANK_ABT,
      BANK_UND
   } bank_t;

   // flag update from the alu
   typedef struct packed {
      logic updNzcv;
      logic [3:0] nzcv;
      logic satHit;
   } alu_flags_t;

   // status write instruction
   typedef struct packed {
      logic en;
      logic toSaved;
      logic [3:0] fieldMask;
      logic [31:0] data;
   } status_wr_t;

   // exception entry
   typedef struct packed {
      logic en;
      logic [4:0] mode;
      logic setF;
   } exc_entry_t;

   function automatic bank_t mode_to_bank(input logic [4:0] mode);
      case (mode)
         MODE_FIQ: return BANK_FIQ;
         MODE_IRQ: return BANK_IRQ;
         MODE_SVC: return BANK_SVC;
         MODE_ABT: return BANK_ABT;
         MODE_UND: return BANK_UND;
         default: return BANK_USR;
      endcase
   endfunction : mode_to_bank

   // logical register 0..15 to physical slot for a given bank
   function automatic logic [4:0] phys_index(input logic [3:0] r, input bank_t b);
      logic [4:0] idx;
      idx = {1'b0, r};
      if (b == BANK_FIQ && r >= 4'h8 && r <= 4'he) begin
         idx = 5'(PHYS_FIQ8 + 5'(r - 4'h8));
      end else if (b != BANK_USR && b != BANK_FIQ && (r == 4'hd || r == 4'he)) begin
         idx = 5'(PHYS_BANK13 + 5'({2'b00, 3'(b) - 3'h2} * 5'h2) + 5'(r - 4'hd));
      end
      return idx;
   endfunction : phys_index

endpackage : regbank_pkg

// ---- rtl/gpr_mem.sv ----
// small two-read one-write memory holding the physical general registers
`timescale 1ns/1ps
module gpr_mem
   import regbank_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [PHYS_W-1:0] rdAddrA,
   input wire logic [PHYS_W-1:0] rdAddrB,
   output logic [31:0] rdDataA,
   output logic [31:0] rdDataB,
   input wire logic wrEn,
   input wire logic [PHYS_W-1:0] wrAddr,
   input wire logic [31:0] wrData
);

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [31:0] mem [PHYS_REGS];

   // contents are indeterminate after reset, so no reset here
   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // registered read ports
   always_ff @(posedge clk_sys) begin
      rdDataA <= mem[rdAddrA];
      rdDataB <= mem[rdAddrB];
   end

endmodule : gpr_mem

// ---- rtl/saved_status_bank.sv ----
// the five saved status words, one per exception mode
`timescale 1ns/1ps
module saved_status_bank
   import regbank_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [2:0] wrSel,
   input wire logic wrEn,
   input wire logic [31:0] wrData,
   input wire logic [2:0] rdSel,
   output logic [31:0] rdData
);

   // ------------------------------------------------------------
   // storage, slot = bank code minus one
   // ------------------------------------------------------------
   logic [31:0] savedQ [NUM_SAVED];

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_SAVED; i++) begin
            savedQ[i] <= ZERO_WORD;
         end
      end else if (wrEn && wrSel != 3'h0) begin
         savedQ[3'(wrSel - 3'h1)] <= wrData;
      end
   end

   // registered read; bank zero has no saved word and reads zero
   always_ff @(posedge clk_sys) begin
      if (sys_rst || rdSel == 3'h0) begin
         rdData <= ZERO_WORD;
      end else begin
         rdData <= savedQ[3'(rdSel - 3'h1)];
      end
   end

endmodule : saved_status_bank

// ---- rtl/banked_register_file_psr.sv ----
// mode-banked general register file with current and saved status words
`timescale 1ns/1ps
module banked_register_file_psr
   import regbank_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [3:0] rdRegA,
   input wire logic [3:0] rdRegB,
   input wire logic rdCompactA,
   input wire logic rdCompactB,
   input wire logic rdHighOkA,
   input wire logic rdHighOkB,
   output logic [31:0] rdDataA,
   output logic [31:0] rdDataB,
   output logic rdIllegalA,
   output logic rdIllegalB,
   input wire logic wrEn,
   input wire logic [3:0] wrReg,
   input wire logic wrCompact,
   input wire logic wrHighOk,
   input wire logic [31:0] wrData,
   output logic wrIllegal,
   input wire alu_flags_t aluFlags,
   input wire status_wr_t statusWr,
   input wire exc_entry_t excEntry,
   input wire logic restoreStatus,
   input wire logic setState,
   input wire logic stateValue,
   input wire logic [3:0] condCode,
   input wire logic isBranch,
   output logic condPass,
   input wire logic irqReq,
   input wire logic fiqReq,
   output logic irqTake,
   output logic fiqTake,
   output logic [31:0] current_status_word,
   output logic [31:0] saved_status_word,
   output logic state_indicator_output,
   output logic modeValid,
   output logic privileged
);

   // ------------------------------------------------------------
   // status word state
   // ------------------------------------------------------------
   logic [31:0] statusQ;
   logic [31:0] statusD;
   logic [4:0] curMode;
   bank_t curBank;
   bank_t wrBank;
   logic [31:0] savedRd;

   assign curMode = statusQ[MODE_LSB +: MODE_W];
   assign curBank = mode_to_bank(curMode);
   assign privileged = (curMode != MODE_USR);
   assign modeValid = (mode_to_bank(curMode) != BANK_USR) || curMode == MODE_USR
      || curMode == MODE_SYS;

   // merge a masked status write into a word; control byte needs privilege
   function automatic logic [31:0] merge_write(input logic [31:0] old,
                                               input status_wr_t w,
                                               input logic priv);
      logic [31:0] m;
      m = MID_BYTES;
      if ((w.fieldMask & FMASK_FLAGS) != 4'h0) begin
         m = m | FLAGS_BYTE;
      end
      if ((w.fieldMask & FMASK_CTRL) != 4'h0 && priv) begin
         m = m | CTRL_BYTE;
      end
      return (old & ~m) | (w.data & m);
   endfunction : merge_write

   // next status word, later updates override earlier ones
   always_comb begin
      statusD = statusQ;
      if (aluFlags.updNzcv) begin
         statusD[FLAG_N_POS:FLAG_V_POS] = aluFlags.nzcv;
      end
      if (setState) begin
         statusD[STATE_T_POS] = stateValue;
      end
      if (restoreStatus && curBank != BANK_USR) begin
         statusD = savedRd;
      end
      if (statusWr.en && !statusWr.toSaved) begin
         // unused bits pass through unmasked so a full word restores
         statusD = merge_write(statusD, statusWr, privileged);
      end
      if (aluFlags.satHit) begin
         statusD[FLAG_Q_POS] = 1'b1; // set wins over a same-cycle clear
      end
      if (excEntry.en) begin
         statusD[MODE_LSB +: MODE_W] = excEntry.mode;
         statusD[MASK_I_POS] = 1'b1;
         statusD[STATE_T_POS] = 1'b0;
         if (excEntry.setF) begin
            statusD[MASK_F_POS] = 1'b1;
         end
      end
   end

   // status register; other bits are indeterminate at reset, zero here
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         statusQ <= STATUS_RESET;
      end else begin
         statusQ <= statusD;
      end
   end

   assign current_status_word = statusQ;
   assign state_indicator_output = statusQ[STATE_T_POS];

   // ------------------------------------------------------------
   // saved status words
   // ------------------------------------------------------------
   logic savedWrEn;
   logic [31:0] savedWrData;

   // exception entry has priority over a software write to the saved word
   always_comb begin
      savedWrEn = 1'b0;
      savedWrData = statusQ;
      wrBank = curBank;
      if (excEntry.en) begin
         savedWrEn = 1'b1;
         wrBank = mode_to_bank(excEntry.mode);
      end else if (statusWr.en && statusWr.toSaved && curBank != BANK_USR) begin
         savedWrEn = 1'b1;
         savedWrData = merge_write(saved_status_word, statusWr, 1'b1);
      end
   end

   saved_status_bank u_saved (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .wrSel(3'(wrBank)),
      .wrEn(savedWrEn),
      .wrData(savedWrData),
      .rdSel(3'(curBank)),
      .rdData(savedRd)
   );

   // saved word read lags a mode change by one cycle (registered memory)
   assign saved_status_word = savedRd;

   // ------------------------------------------------------------
   // general register access
   // ------------------------------------------------------------
   // compact state: low regs, 13-15 direct, others only through high-op forms
   function automatic logic compact_ok(input logic [3:0] r, input logic c,
                                       input logic hi);
      return !c || r < 4'h8 || r >= 4'hd || hi;
   endfunction : compact_ok

   logic [4:0] physA;
   logic [4:0] physB;
   logic [4:0] physW;
   logic wrGo;
   logic [31:0] memA;
   logic [31:0] memB;
   logic [3:0] rdRegAQ;
   logic [3:0] rdRegBQ;

   // physical index follows the present mode combinationally
   assign physA = phys_index(rdRegA, curBank);
   assign physB = phys_index(rdRegB, curBank);
   assign physW = phys_index(wrReg, curBank);
   assign wrIllegal = wrEn && !compact_ok(wrReg, wrCompact, wrHighOk);
   assign wrGo = wrEn && !wrIllegal && wrReg != 4'hf;

   gpr_mem u_gpr (
      .clk_sys(clk_sys),
      .rdAddrA(physA),
      .rdAddrB(physB),
      .rdDataA(memA),
      .rdDataB(memB),
      .wrEn(wrGo),
      .wrAddr(physW),
      .wrData(wrData)
   );

   // illegal compact reads flagged one cycle later with the data
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdIllegalA <= 1'b0;
         rdIllegalB <= 1'b0;
         rdRegAQ <= 4'h0;
         rdRegBQ <= 4'h0;
      end else begin
         rdIllegalA <= !compact_ok(rdRegA, rdCompactA, rdHighOkA);
         rdIllegalB <= !compact_ok(rdRegB, rdCompactB, rdHighOkB);
         rdRegAQ <= rdRegA;
         rdRegBQ <= rdRegB;
      end
   end

   // blocked reads return zero; pc slot is owned by the fetch unit and reads zero
   // here, so its never-written memory slot cannot leak an unknown value
   assign rdDataA = (rdIllegalA || rdRegAQ == 4'hf) ? ZERO_WORD : memA;
   assign rdDataB = (rdIllegalB || rdRegBQ == 4'hf) ? ZERO_WORD : memB;

   // ------------------------------------------------------------
   // condition check and interrupt gating
   // ------------------------------------------------------------
   logic n;
   logic z;
   logic c;
   logic v;
   logic condRaw;

   assign n = statusQ[FLAG_N_POS];
   assign z = statusQ[FLAG_Z_POS];
   assign c = statusQ[FLAG_C_POS];
   assign v = statusQ[FLAG_V_POS];

   // sticky flag deliberately absent from this decode
   always_comb begin
      case (condCode)
         4'h0: condRaw = z;
         4'h1: condRaw = !z;
         4'h2: condRaw = c;
         4'h3: condRaw = !c;
         4'h4: condRaw = n;
         4'h5: condRaw = !n;
         4'h6: condRaw = v;
         4'h7: condRaw = !v;
         4'h8: condRaw = c && !z;
         4'h9: condRaw = !c || z;
         4'ha: condRaw = n == v;
         4'hb: condRaw = n != v;
         4'hc: condRaw = !z && (n == v);
         4'hd: condRaw = z || (n != v);
         default: condRaw = 1'b1;
      endcase
   end

   // compact non-branch instructions always execute
   assign condPass = (statusQ[STATE_T_POS] && !isBranch) ? 1'b1 : condRaw;

   assign irqTake = irqReq && !statusQ[MASK_I_POS];
   assign fiqTake = fiqReq && !statusQ[MASK_F_POS];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_reset_status: assert property (@(posedge clk_sys)
      sys_rst |=> current_status_word[7:0] == 8'hd3) else $error("bad reset");
   a_sticky_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $past(statusQ[FLAG_Q_POS]) && !$past(statusWr.en) && !$past(restoreStatus)
      |-> statusQ[FLAG_Q_POS]) else $error("sticky flag lost");
   a_sticky_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
      aluFlags.satHit |=> statusQ[FLAG_Q_POS]) else $error("sticky not set");
   a_state_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
      setState && !excEntry.en && !restoreStatus && !statusWr.en
      |=> state_indicator_output == $past(stateValue))
      else $error("state pin wrong");
   a_user_ctrl: assert property (@(posedge clk_sys) disable iff (sys_rst)
      curMode == MODE_USR && !excEntry.en && !setState && !restoreStatus
      |=> statusQ[7:0] == $past(statusQ[7:0])) else $error("user ctrl write");
   a_irq_mask: assert property (@(posedge clk_sys) disable iff (sys_rst)
      statusQ[MASK_I_POS] |-> !irqTake) else $error("irq not masked");
   a_exc_mode: assert property (@(posedge clk_sys) disable iff (sys_rst)
      excEntry.en |=> curMode == $past(excEntry.mode) && statusQ[MASK_I_POS]
      ##1 saved_status_word == $past(statusQ, 2)) else $error("entry wrong");
   a_compact_cond: assert property (@(posedge clk_sys) disable iff (sys_rst)
      statusQ[STATE_T_POS] && !isBranch |-> condPass) else $error("compact cond");
   a_high_block: assert property (@(posedge clk_sys) disable iff (sys_rst)
      wrEn && wrCompact && !wrHighOk && wrReg >= 4'h8 && wrReg <= 4'hc |-> wrIllegal)
      else $error("high write allowed");
   a_fiq_bank: assert property (@(posedge clk_sys) disable iff (sys_rst)
      curBank == BANK_FIQ && rdRegA == 4'h8 |-> physA == PHYS_FIQ8)
      else $error("fiq bank");

   c_exc_entry: cover property (@(posedge clk_sys) disable iff (sys_rst) excEntry.en);
   c_sat_hit: cover property (@(posedge clk_sys) disable iff (sys_rst) aluFlags.satHit);
   c_restore: cover property (@(posedge clk_sys) disable iff (sys_rst)
      restoreStatus && curBank != BANK_USR);
   c_fiq_take: cover property (@(posedge clk_sys) disable iff (sys_rst) fiqTake);

endmodule : banked_register_file_psr

// ---- sim/pipe_side_model.sv ----
// pipeline side stand-in: alu flag pulses and the two interrupt request lines
`timescale 1ns/1ps
module pipe_side_model
   import regbank_pkg::*;
(
   input wire logic clk_sys,
   output alu_flags_t aluFlags,
   output logic irqReq,
   output logic fiqReq
);
   // ------------------------------------------------------------
   // drivers
   // ------------------------------------------------------------
   initial begin
      aluFlags = '0;
      irqReq = 1'b0;
      fiqReq = 1'b0;
   end

   // one-cycle flag update; afterwards the flag lines show a changed value
   task automatic pulse(input logic [3:0] nzcv, input logic sat);
      aluFlags = '{1'b1, nzcv, sat};
      @(posedge clk_sys);
      #1;
      aluFlags = '{1'b0, ~nzcv, 1'b0}; // released: stale value must not matter
      @(posedge clk_sys);
      #1;
   endtask : pulse

   // request levels stay up until changed, as interrupt sources do
   task automatic lines(input logic irq, input logic fiq);
      irqReq = irq;
      fiqReq = fiq;
   endtask : lines
endmodule : pipe_side_model

// ---- sim/banked_register_file_psr_test.sv ----
// self-checking bench for the banked register file and status words
`timescale 1ns/1ps
module banked_register_file_psr_test;
   import regbank_pkg::*;
   logic clk_sys, sys_rst, rdCompactA, rdCompactB, rdHighOkA, rdHighOkB, rdIllegalA, rdIllegalB;
   logic [3:0] rdRegA, rdRegB, wrReg, condCode;
   logic [31:0] rdDataA, rdDataB, wrData, statusWord, savedWord, sts, seed;
   logic wrEn, wrCompact, wrHighOk, wrIllegal, restoreStatus, setState, stateValue, isBranch;
   logic condPass, irqReq, fiqReq, irqTake, fiqTake, stateOut, modeValid, privileged;
   alu_flags_t aluFlags;
   status_wr_t statusWr;
   exc_entry_t excEntry;
   logic [31:0] sav [6];
   logic [31:0] mem [int];
   logic [4:0] modes [7] = '{MODE_FIQ, MODE_IRQ, MODE_ABT, MODE_UND, MODE_SVC, MODE_SYS, MODE_USR};
   int num_errors = 0;
   int checked = 0;

   banked_register_file_psr u_banked_register_file_psr (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .rdRegA(rdRegA), .rdRegB(rdRegB), .rdCompactA(rdCompactA), .rdCompactB(rdCompactB),
      .rdHighOkA(rdHighOkA), .rdHighOkB(rdHighOkB), .rdDataA(rdDataA), .rdDataB(rdDataB),
      .rdIllegalA(rdIllegalA), .rdIllegalB(rdIllegalB), .wrEn(wrEn), .wrReg(wrReg),
      .wrCompact(wrCompact), .wrHighOk(wrHighOk), .wrData(wrData), .wrIllegal(wrIllegal),
      .aluFlags(aluFlags), .statusWr(statusWr), .excEntry(excEntry),
      .restoreStatus(restoreStatus), .setState(setState), .stateValue(stateValue),
      .condCode(condCode), .isBranch(isBranch), .condPass(condPass), .irqReq(irqReq),
      .fiqReq(fiqReq), .irqTake(irqTake), .fiqTake(fiqTake), .current_status_word(statusWord),
      .saved_status_word(savedWord), .state_indicator_output(stateOut),
      .modeValid(modeValid), .privileged(privileged));
   pipe_side_model u_pipe_side_model (.clk_sys(clk_sys), .aluFlags(aluFlags),
      .irqReq(irqReq), .fiqReq(fiqReq));

   // ------------------------------------------------------------
   // reference model helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic int bnk(input logic [4:0] m);
      case (m)
         MODE_FIQ: return 1;
         MODE_IRQ: return 2;
         MODE_SVC: return 3;
         MODE_ABT: return 4;
         MODE_UND: return 5;
         default: return 0;
      endcase
   endfunction : bnk

   // storage key: banked copies get their own slot per mode
   function automatic int key(input int r);
      int b;
      b = bnk(sts[4:0]);
      if (r == 13 || r == 14) return b * 16 + r;
      if (r >= 8 && r <= 12 && b == 1) return 16 + r;
      return r;
   endfunction : key

   function automatic logic cond(input logic [3:0] c, input logic [3:0] f);
      logic n, z, cy, v;
      {n, z, cy, v} = f;
      case (c)
         4'h0: return z;
         4'h1: return !z;
         4'h2: return cy;
         4'h3: return !cy;
         4'h4: return n;
         4'h5: return !n;
         4'h6: return v;
         4'h7: return !v;
         4'h8: return cy && !z;
         4'h9: return !cy || z;
         4'ha: return n == v;
         4'hb: return n != v;
         4'hc: return !z && n == v;
         4'hd: return z || n != v;
         default: return 1'b1;
      endcase
   endfunction : cond

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic chk_status();
      int b;
      b = bnk(sts[4:0]);
      cmp("status", sts, statusWord);
      cmp("saved", b != 0 ? sav[b] : ZERO_WORD, savedWord);
      cmp("state", {31'h0, sts[5]}, {31'h0, stateOut});
      cmp("priv", {31'h0, sts[4:0] != MODE_USR}, {31'h0, privileged});
      cmp("valid", 32'h1, {31'h0, modeValid});
      cmp("takes", {30'h0, irqReq & ~sts[7], fiqReq & ~sts[6]},
         {30'h0, irqTake, fiqTake});
   endtask : chk_status

   // ------------------------------------------------------------
   // operations; wr, swr and exc each end with an idle cycle so no strobe is set twice at once, rd does not
   // ------------------------------------------------------------
   task automatic wr(input logic [3:0] r, input logic [31:0] d, input logic cp);
      logic ill;
      ill = cp && !wrHighOk && r >= 4'h8 && r <= 4'hc;
      wrEn = 1'b1;
      wrReg = r;
      wrData = d;
      wrCompact = cp;
      #1;
      cmp("wrIllegal", {31'h0, ill}, {31'h0, wrIllegal});
      tick();
      wrEn = 1'b0;
      if (!ill) mem[key(r)] = d;
      tick();
   endtask : wr

   task automatic rd(input logic [3:0] r, input logic cp, input logic hi);
      logic ill;
      ill = cp && !hi && r >= 4'h8 && r <= 4'hc;
      rdRegA = r;
      rdRegB = r;
      {rdCompactA, rdCompactB, rdHighOkA, rdHighOkB} = {cp, cp, hi, hi};
      tick();
      cmp("rdDataA", ill ? ZERO_WORD : mem[key(r)], rdDataA);
      cmp("rdDataB", ill ? ZERO_WORD : mem[key(r)], rdDataB);
      cmp("rdIllegal", {30'h0, ill, ill}, {30'h0, rdIllegalA, rdIllegalB});
   endtask : rd

   task automatic swr(input logic toSaved, input logic [3:0] mask, input logic [31:0] d);
      logic [31:0] t;
      int b;
      b = bnk(sts[4:0]);
      t = toSaved ? sav[b] : sts;
      t[23:8] = d[23:8];
      if (mask[3]) t[31:24] = d[31:24];
      if (mask[0] && (toSaved || sts[4:0] != MODE_USR)) t[7:0] = d[7:0];
      statusWr = '{1'b1, toSaved, mask, d};
      tick();
      statusWr.en = 1'b0;
      if (!toSaved) sts = t;
      else if (b != 0) sav[b] = t;
      tick();
      chk_status();
   endtask : swr

   task automatic exc(input logic [4:0] m, input logic f);
      excEntry = '{1'b1, m, f};
      tick();
      excEntry.en = 1'b0;
      sav[bnk(m)] = sts;
      sts[7:0] = {1'b1, sts[6] | f, 1'b0, m};
      tick();
      chk_status();
   endtask : exc

   task automatic mode_to(input logic [4:0] m); // valid codes only
      swr(1'b0, FMASK_FLAGS | FMASK_CTRL, (rnd() & 32'hf7ffff00) | {24'h0, sts[7:6], 1'b0, m});
   endtask : mode_to

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   // ------------------------------------------------------------
   // clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   initial begin
      #5000000;
      num_errors++;
      tally_and_finish();
   end

   initial begin
      seed = 32'd44626;
      sys_rst = 1'b1;
      {rdRegA, rdRegB, wrReg, condCode, wrData} = '0;
      {rdCompactA, rdCompactB, rdHighOkA, rdHighOkB, wrEn, wrCompact, wrHighOk} = '0;
      {restoreStatus, setState, stateValue, isBranch} = '0;
      statusWr = '0;
      excEntry = '0;
      sts = STATUS_RESET;
      foreach (sav[i]) sav[i] = ZERO_WORD;
      mem[15] = ZERO_WORD; // pc slot reads zero
      repeat (2) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      chk_status();
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         exc(modes[i], modes[i] == MODE_FIQ);
         for (int r = 8; r < 15; r++) wr(r[3:0], rnd(), 1'b0);
         u_pipe_side_model.pulse(4'(rnd() >> 28), 1'b0);
         sts[31:28] = aluFlags[4:1] ^ 4'hf;
         chk_status();
      end
      mode_to(MODE_SYS);
      for (int r = 0; r < 15; r++) wr(r[3:0], rnd(), 1'b0);
      for (int i = 0; i < 7; i++) begin
         mode_to(modes[i]);
         for (int r = 0; r < 16; r++) rd(r[3:0], 1'b0, 1'b0);
         rd(4'hd, 1'b1, 1'b0);
         rd(4'h9, 1'b1, 1'b0);
         rd(4'h9, 1'b1, 1'b1);
         wr(4'ha, rnd(), 1'b1);
         rd(4'ha, 1'b0, 1'b0);
         wrHighOk = 1'b1; // high move form may reach r8-r12 in compact state
         wr(4'hb, rnd(), 1'b1);
         wrHighOk = 1'b0;
         rd(4'hb, 1'b0, 1'b0);
         if (i < 6) continue;
         swr(1'b0, FMASK_CTRL, {sts[31:8], 8'h13}); // refused in user mode
         swr(1'b1, 4'h9, rnd());
         exc(MODE_UND, 1'b0);
      end
      $display("test banking done");
      u_pipe_side_model.lines(1'b1, 1'b1);
      for (int k = 0; k < 4; k++) begin
         swr(1'b0, FMASK_CTRL, {sts[31:8], k[1:0], 1'b0, MODE_SYS});
      end
      u_pipe_side_model.pulse(4'h5, 1'b1);
      sts[31:27] = {4'h5, 1'b1};
      chk_status();
      u_pipe_side_model.pulse(4'ha, 1'b0);
      sts[31:28] = 4'ha;
      chk_status();
      swr(1'b0, FMASK_FLAGS, {5'h00, sts[26:0]});
      $display("test flags done");
      for (int t = 0; t < 2; t++) begin
         setState = 1'b1;
         stateValue = t[0];
         tick();
         setState = 1'b0;
         sts[5] = t[0];
         tick();
         chk_status();
         for (int c = 0; c < 32; c++) begin
            condCode = c[3:0];
            isBranch = c[0];
            u_pipe_side_model.pulse(4'(rnd() >> 28), c[4]);
            sts[31:28] = aluFlags[4:1] ^ 4'hf;
            sts[27] = sts[27] | c[4];
            cmp("cond", {31'h0, (t == 1 && !c[0]) || cond(c[3:0], sts[31:28])},
               {31'h0, condPass});
         end
      end
      setState = 1'b1;
      stateValue = 1'b0;
      tick();
      setState = 1'b0;
      sts[5] = 1'b0;
      mode_to(MODE_IRQ);
      swr(1'b1, FMASK_FLAGS | FMASK_CTRL, (rnd() & 32'hffffff00) | 32'h00000093);
      restoreStatus = 1'b1;
      tick();
      restoreStatus = 1'b0;
      sts = sav[2];
      tick();
      chk_status();
      $display("test state and restore done");
      tally_and_finish();
   end
endmodule : banked_register_file_psr_test
